// [rtl/rac_pkg.sv]
// Constants, register map and rules of remote access control
//==========================================================================
// What this block does
// - SDA output lags the SDA drive input by 250 ns plus 40 ns per step.
// - Remote-write-block set drops channel writes to own registers.
// - Remote-write-block never stops remote access to local targets.
// - Watchdog expires after about 1 s, 50 us with speed-up.
// - Watchdog disable set: no free-bus detection, no recovery start; a running recovery still completes.
// - SDA high and idle until expiry: bus is free.
// - SDA low and idle until expiry: nine SCL pulses.
// - Bridge address in bits 7:1; zero disables its access.
// - After receive lock, bridge address auto-loads from channel.
// - Freeze set keeps software address, skips the auto-load.
// - Per-link copies; second link select steers register access.
// - Alias 0 access is remapped to remote target 0 address.
// - Zero remote target 0 address blocks forwarding to it.
// - Alias for target 0 is matched; zero alias disables it.
// - Pass-through forwards alias matches; off after reset.
//==========================================================================
package rac_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // Register offsets
    localparam logic [7:0] OFS_PASS_CTRL = 8'h03;
    localparam logic [7:0] OFS_SIDE_CFG = 8'h05;
    localparam logic [7:0] OFS_BRIDGE_ADDR = 8'h06;
    localparam logic [7:0] OFS_TARGET_MAP0 = 8'h07;
    localparam logic [7:0] OFS_TARGET_ALIAS0 = 8'h08;

    // Field positions
    localparam int POS_PASS_EN = 3;
    localparam int POS_SDA_DLY_LO = 3;
    localparam int POS_WR_BLOCK = 2;
    localparam int POS_WD_SPEEDUP = 1;
    localparam int POS_WD_DISABLE = 0;
    localparam int POS_FREEZE = 0;

    // Reset values
    localparam logic [7:0] RST_SIDE_CFG = 8'h00;
    localparam logic [6:0] RST_ADDR7 = 7'h00;
    localparam logic RST_BIT = 1'b0;

    // SDA delay, rounded up to whole cycles
    localparam int SDA_BASE_NS = 240;
    localparam int SDA_STEP_NS = 40;
    localparam int SDA_BASE_CYC = (SDA_BASE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int SDA_STEP_CYC = (SDA_STEP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int SDA_MAX_CYC = SDA_BASE_CYC + 3 * SDA_STEP_CYC;

    // Watchdog periods
    localparam int WD_LONG_NS = 1000000000;
    localparam int WD_SHORT_NS = 50000;
    localparam int WD_LONG_CYC = WD_LONG_NS / CLK_PERIOD_NS;
    localparam int WD_SHORT_CYC = WD_SHORT_NS / CLK_PERIOD_NS;

    // Recovery SCL half period and pulse count
    localparam int RCV_HALF_NS = 5000;
    localparam int RCV_HALF_CYC = RCV_HALF_NS / CLK_PERIOD_NS;
    localparam logic [3:0] RCV_PULSES = 4'h9;

    typedef enum logic [1:0] {
        RAC_WD_IDLE = 2'b00,
        RAC_WD_LOW = 2'b01,
        RAC_WD_HIGH = 2'b10
    } rac_wd_e;
endpackage : rac_pkg

// [rtl/rac_xfer_if.sv]
// Carrier between link clock and core clock logic
interface rac_xfer_if;
    logic req_tgl;
    logic ack_tgl;
    logic [7:0] word;
    logic [1:0] lock;

    modport link (output req_tgl, output word, output lock, input ack_tgl);
    modport core (input req_tgl, input word, input lock, output ack_tgl);
endinterface : rac_xfer_if

// [rtl/rac_link.sv]
// Link clock side: address updates from the channel
module rac_link
    import rac_pkg::*;
(
    input wire logic link_clock,
    input wire logic link_reset,
    input wire logic [1:0] rx_lock,
    input wire logic id_strobe,
    input wire logic id_port,
    input wire logic [6:0] id_value,
    rac_xfer_if.link xfer
);
    logic req_ff;
    logic busy_ff;
    logic [7:0] word_ff;
    logic [1:0] lock_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;

    //======================================================================
    // Acknowledge synchroniser
    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= xfer.ack_tgl;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    //======================================================================
    // Update capture while locked
    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            req_ff <= 1'b0;
            busy_ff <= 1'b0;
            word_ff <= 8'h00;
        end else if (!busy_ff) begin
            if (id_strobe && rx_lock[id_port]) begin
                word_ff <= {id_port, id_value};
                req_ff <= ~req_ff;
                busy_ff <= 1'b1;
            end
        end else if (ack_s2_ff == req_ff) begin
            busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            lock_ff <= 2'b00;
        end else begin
            lock_ff <= rx_lock;
        end
    end

    assign xfer.req_tgl = req_ff;
    assign xfer.word = word_ff;
    assign xfer.lock = lock_ff;
endmodule // rac_link

// [rtl/rac_top.sv]
// Top of the I2C remote access control block
module rac_top
    import rac_pkg::*;
#(
    parameter int WD_LONG = WD_LONG_CYC,
    parameter int WD_SHORT = WD_SHORT_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic link_clock,
    input wire logic link_reset,
    input wire logic second_link_select,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_remote,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [1:0] rx_lock,
    input wire logic id_strobe,
    input wire logic id_port,
    input wire logic [6:0] id_value,
    input wire logic fwd_req,
    input wire logic fwd_port,
    input wire logic [6:0] fwd_addr,
    output logic fwd_valid,
    output logic fwd_hit,
    output logic fwd_out_port,
    output logic [6:0] fwd_out_addr,
    input wire logic sda_drive_low,
    input wire logic scl_drive_low,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    output logic bus_free
);
    localparam int WDW = $clog2(WD_LONG + 1);
    localparam int RCW = $clog2(RCV_HALF_CYC + 1);
    rac_xfer_if xfer ();
    rac_link u_link (
        .link_clock(link_clock),
        .link_reset(link_reset),
        .rx_lock(rx_lock),
        .id_strobe(id_strobe),
        .id_port(id_port),
        .id_value(id_value),
        .xfer(xfer)
    );

    function automatic logic hit(input logic [7:0] a, o);
        hit = (a == o);
    endfunction
    //======================================================================
    // Register storage
    logic [1:0] sda_dly_ff;
    logic wr_block_ff;
    logic wd_speedup_ff;
    logic wd_disable_ff;
    logic pass_en_ff [2];
    logic freeze_ff [2];
    logic [6:0] bridge_ff [2];
    logic [6:0] target_ff [2];
    logic [6:0] alias_ff [2];
    logic wr_ok;
    logic sel;
    logic [7:0] nxt_rdata;

    assign sel = second_link_select;
    assign wr_ok = reg_wr && !(reg_remote && wr_block_ff);

    always_ff @(posedge clock) begin
        if (reset) begin
            sda_dly_ff <= RST_SIDE_CFG[POS_SDA_DLY_LO +: 2];
            wr_block_ff <= RST_SIDE_CFG[POS_WR_BLOCK];
            wd_speedup_ff <= RST_SIDE_CFG[POS_WD_SPEEDUP];
            wd_disable_ff <= RST_SIDE_CFG[POS_WD_DISABLE];
        end else if (clock_enable && wr_ok && hit(reg_addr, OFS_SIDE_CFG)) begin
            sda_dly_ff <= reg_wdata[POS_SDA_DLY_LO +: 2];
            wr_block_ff <= reg_wdata[POS_WR_BLOCK];
            wd_speedup_ff <= reg_wdata[POS_WD_SPEEDUP];
            wd_disable_ff <= reg_wdata[POS_WD_DISABLE];
        end
    end

    //======================================================================
    // Address update crossing from link clock
    logic req_s1_ff;
    logic req_s2_ff;
    logic req_s3_ff;
    logic [1:0] lock_s1_ff;
    logic [1:0] lock_s2_ff;
    logic upd;
    logic upd_port;

    always_ff @(posedge clock) begin
        if (reset) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            lock_s1_ff <= 2'b00;
            lock_s2_ff <= 2'b00;
        end else if (clock_enable) begin
            req_s1_ff <= xfer.req_tgl;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            lock_s1_ff <= xfer.lock;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    assign xfer.ack_tgl = req_s3_ff;
    assign upd = (req_s2_ff != req_s3_ff);
    assign upd_port = xfer.word[7];

    //======================================================================
    // Per-link copies
    generate
        for (genvar p = 0; p < 2; p++) begin : g_link
            logic sw_sel;
            logic auto_ld;
            assign sw_sel = (sel == 1'(p)) && wr_ok;
            assign auto_ld = upd && (upd_port == 1'(p)) && lock_s2_ff[p]
                             && !freeze_ff[p];

            always_ff @(posedge clock) begin
                if (reset) begin
                    pass_en_ff[p] <= RST_BIT;
                    freeze_ff[p] <= RST_BIT;
                    bridge_ff[p] <= RST_ADDR7;
                    target_ff[p] <= RST_ADDR7;
                    alias_ff[p] <= RST_ADDR7;
                end else if (clock_enable) begin
                    if (sw_sel && hit(reg_addr, OFS_PASS_CTRL)) begin
                        pass_en_ff[p] <= reg_wdata[POS_PASS_EN];
                    end
                    if (sw_sel && hit(reg_addr, OFS_BRIDGE_ADDR)) begin
                        bridge_ff[p] <= reg_wdata[7:1];
                        freeze_ff[p] <= reg_wdata[POS_FREEZE];
                    end else if (auto_ld) begin
                        bridge_ff[p] <= xfer.word[6:0];
                    end
                    if (sw_sel && hit(reg_addr, OFS_TARGET_MAP0)) begin
                        target_ff[p] <= reg_wdata[7:1];
                    end
                    if (sw_sel && hit(reg_addr, OFS_TARGET_ALIAS0)) begin
                        alias_ff[p] <= reg_wdata[7:1];
                    end
                end
            end
        end
    endgenerate

    //======================================================================
    // Register read
    always_comb begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            OFS_PASS_CTRL: begin
                nxt_rdata[POS_PASS_EN] = pass_en_ff[sel];
            end
            OFS_SIDE_CFG: begin
                nxt_rdata[POS_SDA_DLY_LO +: 2] = sda_dly_ff;
                nxt_rdata[POS_WR_BLOCK] = wr_block_ff;
                nxt_rdata[POS_WD_SPEEDUP] = wd_speedup_ff;
                nxt_rdata[POS_WD_DISABLE] = wd_disable_ff;
            end
            OFS_BRIDGE_ADDR: begin
                nxt_rdata = {bridge_ff[sel], freeze_ff[sel]};
            end
            OFS_TARGET_MAP0: begin
                nxt_rdata = {target_ff[sel], 1'b0};
            end
            OFS_TARGET_ALIAS0: begin
                nxt_rdata = {alias_ff[sel], 1'b0};
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clock_enable) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    //======================================================================
    // Forwarding of local transactions
    logic al_hit;
    logic br_hit;

    assign al_hit = pass_en_ff[fwd_port] && (alias_ff[fwd_port] != 7'h00)
                    && (fwd_addr == alias_ff[fwd_port]);
    assign br_hit = (bridge_ff[fwd_port] != 7'h00)
                    && (fwd_addr == bridge_ff[fwd_port]);

    always_ff @(posedge clock) begin
        if (reset) begin
            fwd_valid <= 1'b0;
            fwd_hit <= 1'b0;
            fwd_out_port <= 1'b0;
            fwd_out_addr <= 7'h00;
        end else if (clock_enable) begin
            fwd_valid <= fwd_req;
            if (fwd_req) begin
                fwd_out_port <= fwd_port;
                if (br_hit) begin
                    fwd_hit <= 1'b1;
                    fwd_out_addr <= fwd_addr;
                end else if (al_hit && target_ff[fwd_port] != 7'h00) begin
                    fwd_hit <= 1'b1;
                    fwd_out_addr <= target_ff[fwd_port];
                end else begin
                    fwd_hit <= 1'b0;
                    fwd_out_addr <= 7'h00;
                end
            end
        end
    end

    //======================================================================
    // SDA output delay line
    logic [SDA_MAX_CYC-1:0] sda_line_ff;
    logic [5:0] sda_tap;

    assign sda_tap = 6'(SDA_BASE_CYC - 1)
                     + 6'(sda_dly_ff) * 6'(SDA_STEP_CYC);

    always_ff @(posedge clock) begin
        if (reset) begin
            sda_line_ff <= '0;
            sda_oe <= 1'b0;
        end else if (clock_enable) begin
            sda_line_ff <= {sda_line_ff[SDA_MAX_CYC-2:0], sda_drive_low};
            sda_oe <= sda_line_ff[sda_tap];
        end
    end

    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    //======================================================================
    // Bus pin synchronisers and activity
    logic scl_s1_ff;
    logic scl_s2_ff;
    logic scl_s3_ff;
    logic sda_s1_ff;
    logic sda_s2_ff;
    logic sda_s3_ff;
    logic activity;

    always_ff @(posedge clock) begin
        if (reset) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
        end else if (clock_enable) begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
        end
    end

    assign activity = (scl_s2_ff != scl_s3_ff) || (sda_s2_ff != sda_s3_ff);

    //======================================================================
    // Watchdog and bus recovery
    rac_wd_e wd_state_ff;
    logic [WDW-1:0] wd_cnt_ff;
    logic [WDW-1:0] wd_limit;
    logic [RCW-1:0] half_ff;
    logic [3:0] pulses_ff;
    logic expired;
    logic rcv_low;

    assign wd_limit = wd_speedup_ff ? WDW'(WD_SHORT - 1)
                                    : WDW'(WD_LONG - 1);
    assign expired = (wd_state_ff == RAC_WD_IDLE) && !wd_disable_ff
                     && !bus_free && !activity && (wd_cnt_ff >= wd_limit);

    always_ff @(posedge clock) begin
        if (reset) begin
            wd_cnt_ff <= '0;
        end else if (clock_enable) begin
            if (wd_disable_ff || activity || expired
                || wd_state_ff != RAC_WD_IDLE) begin
                wd_cnt_ff <= '0;
            end else if (!bus_free) begin
                wd_cnt_ff <= wd_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            bus_free <= 1'b0;
        end else if (clock_enable) begin
            if (wd_disable_ff || activity) begin
                bus_free <= 1'b0;
            end else if (expired && sda_s2_ff) begin
                bus_free <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wd_state_ff <= RAC_WD_IDLE;
            half_ff <= '0;
            pulses_ff <= 4'h0;
        end else if (clock_enable) begin
            case (wd_state_ff)
                RAC_WD_IDLE: begin
                    half_ff <= '0;
                    pulses_ff <= 4'h0;
                    if (expired && !sda_s2_ff) begin
                        wd_state_ff <= RAC_WD_LOW;
                    end
                end
                RAC_WD_LOW: begin
                    if (half_ff == RCW'(RCV_HALF_CYC - 1)) begin
                        half_ff <= '0;
                        pulses_ff <= pulses_ff + 4'h1;
                        wd_state_ff <= RAC_WD_HIGH;
                    end else begin
                        half_ff <= half_ff + 1'b1;
                    end
                end
                RAC_WD_HIGH: begin
                    if (half_ff == RCW'(RCV_HALF_CYC - 1)) begin
                        half_ff <= '0;
                        if (pulses_ff == RCV_PULSES) begin
                            wd_state_ff <= RAC_WD_IDLE;
                        end else begin
                            wd_state_ff <= RAC_WD_LOW;
                        end
                    end else begin
                        half_ff <= half_ff + 1'b1;
                    end
                end
                default: begin
                    wd_state_ff <= RAC_WD_IDLE;
                end
            endcase
        end
    end

    assign rcv_low = (wd_state_ff == RAC_WD_LOW);
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_oe <= 1'b0;
        end else if (clock_enable) begin
            scl_oe <= scl_drive_low || rcv_low;
        end
    end
endmodule // rac_top

// [verif/rac_far_model.sv]
// Far end model: remote bridge reporting its address
module rac_far_model (
    input wire logic link_clock,
    output logic [1:0] rx_lock,
    output logic id_strobe,
    output logic id_port,
    output logic [6:0] id_value
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {rx_lock, id_strobe, id_port, id_value} = '0;
    task automatic set_lock(input logic [1:0] lk);
        @(posedge link_clock);
        #1;
        rx_lock = lk;
    endtask
    task automatic send(input logic p, input logic [6:0] v);
        @(posedge link_clock);
        #1;
        id_port = p;
        id_value = v;
        id_strobe = 1'b1;
        @(posedge link_clock);
        #1;
        id_strobe = 1'b0;
        id_port = ~p;
        id_value = ~v;
        repeat (5) @(posedge link_clock);
    endtask
endmodule // rac_far_model

// [verif/rac_top_chk.sv]
// Port checker of the remote access control
module rac_top_chk
    import rac_pkg::*;
#(
    parameter int WD_LONG = WD_LONG_CYC,
    parameter int WD_SHORT = WD_SHORT_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_remote,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic fwd_req,
    input wire logic fwd_valid,
    input wire logic fwd_hit,
    input wire logic [6:0] fwd_out_addr,
    input wire logic sda_drive_low,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic bus_free
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cfg_ff;
    logic [15:0] idle_ff;
    logic [5:0] quiet_ff;
    logic [1:0] pin_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    //======================================================================
    // Helper state
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg_ff <= 8'h00;
        end else if (reg_wr && reg_addr == OFS_SIDE_CFG
                     && !(reg_remote && cfg_ff[POS_WR_BLOCK])) begin
            cfg_ff <= reg_wdata;
        end
    end
    always_ff @(posedge clock) begin
        pin_ff <= {sda_in, scl_in};
        if (reset || pin_ff != {sda_in, scl_in}) begin
            idle_ff <= 16'h0000;
        end else if (idle_ff != 16'hFFFF) begin
            idle_ff <= idle_ff + 16'h0001;
        end
    end
    always_ff @(posedge clock) begin
        if (reset || sda_drive_low) begin
            quiet_ff <= 6'h00;
        end else if (quiet_ff != 6'h3F) begin
            quiet_ff <= quiet_ff + 6'h01;
        end
    end
    //======================================================================
    // Assertions
    a_read_answer: assert property (
        reg_rd |=> reg_rvalid) else $error("no rvalid");
    a_rsvd_cfg: assert property (
        reg_rd && reg_addr == OFS_SIDE_CFG |=> reg_rdata[7:5] == 3'h0)
        else $error("cfg rsvd set");
    a_rsvd_map: assert property (
        reg_rd && reg_addr == OFS_TARGET_MAP0 |=> !reg_rdata[0])
        else $error("map rsvd set");
    a_fwd_answer: assert property (
        fwd_req |=> fwd_valid) else $error("no fwd_valid");
    a_miss_zero: assert property (
        fwd_valid && !fwd_hit |-> fwd_out_addr == 7'h00)
        else $error("miss with addr");
    a_sda_lag: assert property (
        $rose(sda_oe) |-> $past(sda_drive_low, 25) || $past(sda_drive_low, 29)
        || $past(sda_drive_low, 33) || $past(sda_drive_low, 37))
        else $error("sda delay off");
    a_sda_quiet: assert property (
        quiet_ff >= 6'h28 |-> !sda_oe) else $error("stray sda");
    a_wd_off: assert property (
        cfg_ff[POS_WD_DISABLE] && $past(cfg_ff[POS_WD_DISABLE], 3)
        |-> !bus_free && !scl_oe) else $error("wd acts off");
    a_free_high: assert property (
        $rose(bus_free) |-> $past(sda_in, 3)) else $error("free with sda low");
    a_free_idle: assert property (
        $rose(bus_free) |-> int'(idle_ff) >= ((cfg_ff[POS_WD_SPEEDUP]
        || $past(cfg_ff[POS_WD_SPEEDUP], 3)) ? WD_SHORT : WD_LONG))
        else $error("wd early");
    a_scl_pulse: assert property (
        $rose(scl_oe) |-> !$past(sda_in, 3) ##1 scl_oe [*8])
        else $error("bad pulse");
    c_free: cover property ($rose(bus_free));
    c_recover: cover property ($rose(scl_oe));
    c_hit: cover property (fwd_valid && fwd_hit);
endmodule // rac_top_chk
bind rac_top rac_top_chk #(.WD_LONG(WD_LONG), .WD_SHORT(WD_SHORT)) chk (
    .clock, .reset, .reg_wr, .reg_rd, .reg_remote, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .fwd_req, .fwd_valid, .fwd_hit, .fwd_out_addr,
    .sda_drive_low, .sda_in, .sda_oe, .scl_in, .scl_oe, .bus_free);

// [verif/rac_top_tb.sv]
// Bench of the remote access control
module rac_top_tb;
    import rac_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WL = 2000;
    localparam int WS = 300;
    logic clock, reset, link_clock, sel, rwr, rrd, rrem, freq, fport;
    logic [7:0] radr, rwd, rdat;
    logic rval, fval, fhit, fop, sdrv, sext, sclx, soe, coe, bfree;
    logic [6:0] fadr, fout, idv, al, tg, br;
    logic [1:0] lock;
    logic ids, idp;
    int error_cnt;
    int comparisons;
    int n;
    logic p;
    logic [7:0] rd_q[$];
    logic [8:0] fw_q[$];
    rac_top #(.WD_LONG(WL), .WD_SHORT(WS)) dut (.clock,
        .reset, .clock_enable(1'b1), .link_clock,
        .link_reset(reset), .second_link_select(sel), .reg_wr(rwr),
        .reg_rd(rrd), .reg_remote(rrem), .reg_addr(radr), .reg_wdata(rwd),
        .reg_rdata(rdat), .reg_rvalid(rval), .rx_lock(lock),
        .id_strobe(ids), .id_port(idp), .id_value(idv), .fwd_req(freq),
        .fwd_port(fport), .fwd_addr(fadr), .fwd_valid(fval),
        .fwd_hit(fhit), .fwd_out_port(fop), .fwd_out_addr(fout),
        .sda_drive_low(sdrv), .scl_drive_low(1'b0), .sda_in(sext & ~soe),
        .sda_out(), .sda_oe(soe), .scl_in(sclx & ~coe), .scl_out(),
        .scl_oe(coe), .bus_free(bfree));
    rac_far_model far (.link_clock(link_clock), .rx_lock(lock),
        .id_strobe(ids), .id_port(idp), .id_value(idv));
    //======================================================================
    // Clocks and tasks
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #3.7;
        forever #80 link_clock = ~link_clock;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic cmp(input logic [8:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d, input logic rem = 1'b0);
        cyc(1);
        radr = a;
        rwd = d;
        rrem = rem;
        rwr = 1'b1;
        cyc(1);
        rwr = 1'b0;
        rrem = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        rd_q.push_back(e);
        cyc(1);
        radr = a;
        rrd = 1'b1;
        cyc(1);
        rrd = 1'b0;
    endtask
    task automatic fw(input logic pt, input logic [6:0] a, input logic [7:0] e);
        fw_q.push_back({pt, e});
        cyc(1);
        fport = pt;
        fadr = a;
        freq = 1'b1;
        cyc(1);
        freq = 1'b0;
    endtask
    task automatic kick();
        cyc(1);
        sclx = 1'b0;
        cyc(3);
        sclx = 1'b1;
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        #2;
        if (rval === 1'b1) cmp(rdat, rd_q.pop_front());
        if (fval === 1'b1) cmp({fop, fhit, fout}, fw_q.pop_front());
    end
    initial begin
        cyc(60000);
        error_cnt++;
        print_verdict();
    end
    //======================================================================
    // Main sequence
    initial begin
        {reset, sel, rwr, rrd, rrem, freq, fport, sdrv} = 8'h80;
        {radr, rwd, fadr} = '0;
        sext = 1'b1;
        sclx = 1'b1;
        void'($urandom(32'hB9E18246));
        al = 7'h10 + 7'($urandom_range(0, 15));
        tg = 7'h40 + 7'($urandom_range(0, 15));
        br = 7'h60 + 7'($urandom_range(0, 15));
        cyc(20);
        reset = 1'b0;
        rd(OFS_SIDE_CFG, 8'h00);
        rd(OFS_BRIDGE_ADDR, 8'h00);
        rd(OFS_TARGET_MAP0, 8'h00);
        rd(8'h10 + 8'($urandom_range(0, 200)), 8'h00);
        wr(OFS_SIDE_CFG, 8'hFF);
        rd(OFS_SIDE_CFG, 8'h1F);
        wr(OFS_TARGET_MAP0, 8'hFF);
        rd(OFS_TARGET_MAP0, 8'hFE);
        wr(OFS_SIDE_CFG, 8'h04);
        wr(OFS_TARGET_MAP0, 8'h22, 1'b1);
        rd(OFS_TARGET_MAP0, 8'hFE);
        wr(OFS_SIDE_CFG, 8'h00, 1'b1);
        rd(OFS_SIDE_CFG, 8'h04);
        wr(OFS_SIDE_CFG, 8'h00);
        wr(OFS_TARGET_MAP0, 8'h22, 1'b1);
        rd(OFS_TARGET_MAP0, 8'h22);
        wr(OFS_TARGET_ALIAS0, {al, 1'b0});
        wr(OFS_TARGET_MAP0, {tg, 1'b0});
        fw(1'b0, al, 8'h00);
        wr(OFS_PASS_CTRL, 8'h08);
        fw(1'b0, al, {1'b1, tg});
        fw(1'b0, tg, 8'h00);
        wr(OFS_TARGET_MAP0, 8'h00);
        fw(1'b0, al, 8'h00);
        wr(OFS_TARGET_ALIAS0, 8'h00);
        fw(1'b0, 7'h00, 8'h00);
        wr(OFS_BRIDGE_ADDR, {br, 1'b1});
        fw(1'b0, br, {1'b1, br});
        wr(OFS_BRIDGE_ADDR, 8'h00);
        fw(1'b0, 7'h00, 8'h00);
        sel = 1'b1;
        wr(OFS_PASS_CTRL, 8'h08);
        wr(OFS_TARGET_ALIAS0, {al, 1'b0});
        wr(OFS_TARGET_MAP0, {br, 1'b0});
        fw(1'b1, al, {1'b1, br});
        fw(1'b0, al, 8'h00);
        sel = 1'b0;
        rd(OFS_TARGET_MAP0, 8'h00);
        far.set_lock(2'b01);
        far.send(1'b0, br);
        cyc(10);
        rd(OFS_BRIDGE_ADDR, {br, 1'b0});
        wr(OFS_BRIDGE_ADDR, {tg, 1'b1});
        far.send(1'b0, al);
        cyc(10);
        rd(OFS_BRIDGE_ADDR, {tg, 1'b1});
        far.send(1'b1, al);
        cyc(10);
        sel = 1'b1;
        rd(OFS_BRIDGE_ADDR, 8'h00);
        sel = 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_SIDE_CFG, 8'(s << 3));
            cyc(1);
            sdrv = 1'b1;
            n = 0;
            while (soe !== 1'b1 && n < 60) begin
                cyc(1);
                n++;
            end
            cmp(8'(n), 8'(SDA_BASE_CYC + 1 + s * SDA_STEP_CYC));
            sdrv = 1'b0;
            cyc(45);
        end
        wr(OFS_SIDE_CFG, 8'h02);
        kick();
        cyc(WS - 10);
        cmp(bfree, 8'h00);
        cyc(30);
        cmp(bfree, 8'h01);
        wr(OFS_SIDE_CFG, 8'h00);
        kick();
        cyc(WS + 30);
        cmp(bfree, 8'h00);
        cyc(WL);
        cmp(bfree, 8'h01);
        wr(OFS_SIDE_CFG, 8'h01);
        kick();
        cyc(WL + 30);
        cmp(bfree, 8'h00);
        wr(OFS_SIDE_CFG, 8'h02);
        sext = 1'b0;
        kick();
        n = 0;
        p = 1'b0;
        repeat (9000) begin
            cyc(1);
            if (coe === 1'b1 && !p) n++;
            p = coe;
        end
        cmp(8'(n), 8'(RCV_PULSES));
        cmp(8'(rd_q.size() + fw_q.size()), 8'h00);
        print_verdict();
    end
endmodule // rac_top_tb
